/* File: rtl/spi_master_defs.vh */
// Constants for the serial master transfer controller
`ifndef SPI_MASTER_DEFS_VH
`define SPI_MASTER_DEFS_VH
`define SEL_W 3
`define DIV_W 8
`define LEN_W 6
`define DATA_W 32
`define LEN_MIN 6'h01
`define LEN_MAX 6'h20
`define CFG_W 23
// Config word field positions for save and restore
`define CFG_SEL_LSB 0
`define CFG_DIV_LSB 3
`define CFG_AUTO_BIT 11
`define CFG_IRQ_BIT 12
`define CFG_LSBF_BIT 13
`define CFG_POL_BIT 14
`define CFG_PHA_BIT 15
`define CFG_LEN_LSB 16
`define CFG_NSLV_BIT 22
`define DIV_RESET 8'h01
`endif

/* File: rtl/clk_div_enable.v */
// Divider producing a one-cycle enable every div cycles
`timescale 1ns/1ps
`include "spi_master_defs.vh"
module clk_div_enable (
  // Clock and reset
  input wire clk_sys,
  input wire rst_n,
  // Control
  input wire run,
  input wire [`DIV_W-1:0] div,
  // Output
  output reg tick
);
  reg [`DIV_W-1:0] cnt_r;
  wire [`DIV_W-1:0] last = (div == 8'h00) ? 8'h00 : div - 8'h01;

  always @(posedge clk_sys) begin
    if (!rst_n || !run) begin
      cnt_r <= 8'h00;
      tick <= 1'b0;
    end else if (cnt_r >= last) begin
      cnt_r <= 8'h00;
      tick <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 8'h01;
      tick <= 1'b0;
    end
  end
endmodule

/* File: rtl/spi_master_transfer_ctrl.v */
// Serial peripheral master: clock, data and three selects
// Summary of operation
// - Auto select: lines active only during transfer
// - Manual select: lines follow written selection immediately
// - Length 1 to 32 bits per transfer
// - Received word right justified in 32 bits
// - Busy set during transfer, cleared after
// - Done interrupt pulse when enabled
// - Slaves, divisor, auto select, irq configurable
// - LSB first or MSB first order
// - Polarity and phase selectable
// - Configuration readable and restorable whole
// - Continuous mode waits for received word read
// - Continuous mode restarts after read automatically
// - Disabling continuous ends after the running transfer, or after one more if waiting
// - Three slave select outputs
// - Modes map polarity and phase to edges
// - Full duplex, one bit each way per cycle
`timescale 1ns/1ps
`include "spi_master_defs.vh"
module spi_master_transfer_ctrl (
  // Clock and reset
  input wire clk_sys,
  input wire rst_n,
  // Configuration
  input wire [`SEL_W-1:0] slave_sel,
  input wire [`DIV_W-1:0] clk_divisor,
  input wire auto_select,
  input wire irq_enable,
  input wire lsb_first,
  input wire clk_invert,
  input wire clk_phase,
  input wire slave_count_sel,
  input wire cfg_write,
  output wire [`CFG_W-1:0] cfg_read,
  input wire [`CFG_W-1:0] cfg_restore,
  input wire cfg_restore_load,
  // Transfer control
  input wire start,
  input wire continuous,
  input wire stop,
  input wire [`LEN_W-1:0] xfer_len,
  input wire [`DATA_W-1:0] tx_data,
  input wire rx_read,
  output reg [`DATA_W-1:0] rx_data,
  output wire busy,
  output reg master_transfer_done_irq,
  // Serial pins
  output reg serial_clock_out,
  output reg serial_data_out,
  input wire serial_data_in,
  output wire slave_select_line_a_n,
  output wire slave_select_line_b_n,
  output wire slave_select_line_c_n
);
  localparam ST_IDLE = 4'b0001;
  localparam ST_RUN = 4'b0010;
  localparam ST_WAIT = 4'b0100;
  localparam ST_END = 4'b1000;

  ////////////////////////////////////////////////////////////////////////
  // Configuration store
  reg [`SEL_W-1:0] sel_r;
  reg [`DIV_W-1:0] div_r;
  reg auto_r, irq_en_r, lsbf_r, pol_r, pha_r, nslv_r;
  reg [`LEN_W-1:0] len_r;

  always @(posedge clk_sys) begin
    if (!rst_n || stop) begin
      sel_r <= 3'h0;
      if (!rst_n) begin
        div_r <= `DIV_RESET;
        auto_r <= 1'b0;
        irq_en_r <= 1'b0;
        lsbf_r <= 1'b0;
        pol_r <= 1'b0;
        pha_r <= 1'b0;
        nslv_r <= 1'b0;
      end
    end else if (cfg_restore_load) begin
      // Whole configuration restored from a saved word
      sel_r <= cfg_restore[`CFG_SEL_LSB+2:`CFG_SEL_LSB];
      div_r <= cfg_restore[`CFG_DIV_LSB+7:`CFG_DIV_LSB];
      auto_r <= cfg_restore[`CFG_AUTO_BIT];
      irq_en_r <= cfg_restore[`CFG_IRQ_BIT];
      lsbf_r <= cfg_restore[`CFG_LSBF_BIT];
      pol_r <= cfg_restore[`CFG_POL_BIT];
      pha_r <= cfg_restore[`CFG_PHA_BIT];
      nslv_r <= cfg_restore[`CFG_NSLV_BIT];
    end else if (cfg_write) begin
      sel_r <= slave_sel;
      div_r <= clk_divisor;
      auto_r <= auto_select;
      irq_en_r <= irq_enable;
      lsbf_r <= lsb_first;
      pol_r <= clk_invert;
      pha_r <= clk_phase;
      nslv_r <= slave_count_sel;
    end
  end

  assign cfg_read = {nslv_r, len_r, pha_r, pol_r, lsbf_r, irq_en_r,
    auto_r, div_r, sel_r};

  ////////////////////////////////////////////////////////////////////////
  // Transfer sequencing
  reg [3:0] state_r;
  reg cont_r;
  reg half_r;
  reg [`LEN_W-1:0] cnt_r;
  reg [`DATA_W-1:0] tx_sh_r, rx_sh_r;
  reg [`DATA_W-1:0] tx_keep_r;
  reg din_s1_r, din_s2_r;
  wire tick;
  wire [`LEN_W-1:0] len_ok = (xfer_len == 6'h00) ? `LEN_MIN :
    (xfer_len > `LEN_MAX) ? `LEN_MAX : xfer_len;

  clk_div_enable u_div (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .run(state_r == ST_RUN),
    .div(div_r),
    .tick(tick)
  );

  // Length has one owner: taken at start, else restored with the config
  wire take_start = (state_r == ST_IDLE) && (start || continuous) && !stop;

  always @(posedge clk_sys) begin
    if (!rst_n)
      len_r <= `LEN_MAX;
    else if (take_start)
      len_r <= len_ok;
    else if (cfg_restore_load && !stop)
      len_r <= cfg_restore[`CFG_LEN_LSB+5:`CFG_LEN_LSB];
  end

  always @(posedge clk_sys) begin
    din_s1_r <= serial_data_in;
    din_s2_r <= din_s1_r;
  end

  assign busy = (state_r == ST_RUN) || (state_r == ST_END);

  // Bit to send next for given index within current length
  function next_bit;
    input [`DATA_W-1:0] d;
    input [`LEN_W-1:0] idx;
    input [`LEN_W-1:0] len;
    input lsbf;
    reg [`LEN_W-1:0] p;
    begin
      p = lsbf ? idx : len - 6'h01 - idx;
      next_bit = d[p[4:0]];
    end
  endfunction

  wire lead_edge = tick && !half_r;
  wire trail_edge = tick && half_r;
  wire sample_now = pha_r ? trail_edge : lead_edge;
  wire [`DATA_W-1:0] rx_ins = lsbf_r ?
    {din_s2_r, rx_sh_r[`DATA_W-1:1]} : {rx_sh_r[`DATA_W-2:0], din_s2_r};

  always @(posedge clk_sys) begin
    master_transfer_done_irq <= 1'b0;
    if (!rst_n) begin
      state_r <= ST_IDLE;
      cont_r <= 1'b0;
      half_r <= 1'b0;
      cnt_r <= 6'h00;
      tx_sh_r <= 32'h00000000;
      tx_keep_r <= 32'h00000000;
      rx_sh_r <= 32'h00000000;
      rx_data <= 32'h00000000;
      serial_clock_out <= 1'b0;
      serial_data_out <= 1'b0;
    end else begin
      if (continuous)
        cont_r <= 1'b1;
      else if (!continuous && state_r != ST_IDLE)
        cont_r <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          serial_clock_out <= pol_r;
          if (take_start) begin
            tx_sh_r <= tx_data;
            tx_keep_r <= tx_data;
            rx_sh_r <= 32'h00000000;
            cnt_r <= 6'h00;
            half_r <= 1'b0;
            cont_r <= continuous;
            serial_data_out <= next_bit(tx_data, 6'h00, len_ok, lsbf_r);
            state_r <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (tick) begin
            half_r <= ~half_r;
            serial_clock_out <= ~serial_clock_out;
            if (sample_now)
              rx_sh_r <= rx_ins;
            if (!pha_r && trail_edge && cnt_r != len_r - 6'h01)
              serial_data_out <= next_bit(tx_sh_r, cnt_r + 6'h01,
                len_r, lsbf_r);
            if (pha_r && lead_edge)
              serial_data_out <= next_bit(tx_sh_r, cnt_r, len_r, lsbf_r);
            if (trail_edge) begin
              cnt_r <= cnt_r + 6'h01;
              if (cnt_r == len_r - 6'h01)
                state_r <= ST_END;
            end
          end
        end
        ST_END: begin
          // Right justify: MSB-first fills from bit 0 already
          if (lsbf_r)
            rx_data <= rx_sh_r >> (6'h20 - len_r);
          else
            rx_data <= rx_sh_r;
          serial_clock_out <= pol_r;
          master_transfer_done_irq <= irq_en_r;
          state_r <= cont_r ? ST_WAIT : ST_IDLE;
        end
        ST_WAIT: begin
          if (stop)
            state_r <= ST_IDLE;
          else if (rx_read) begin
            // Repeat at the same length with the kept transmit word
            tx_sh_r <= tx_keep_r;
            rx_sh_r <= 32'h00000000;
            cnt_r <= 6'h00;
            half_r <= 1'b0;
            serial_data_out <= next_bit(tx_keep_r, 6'h00, len_r, lsbf_r);
            state_r <= ST_RUN;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Slave selects, active low
  wire sel_on = auto_r ? busy : 1'b1;
  wire [`SEL_W-1:0] sel_act = sel_on ? sel_r : 3'h0;
  assign slave_select_line_a_n = ~sel_act[0];
  assign slave_select_line_b_n = ~sel_act[1];
  assign slave_select_line_c_n = ~sel_act[2];
endmodule

/* File: verif/spi_master_props.sv */
// Checker on the serial master ports
`timescale 1ns/1ps
`include "spi_master_defs.vh"
module spi_master_props (
  input clk_sys, rst_n, busy, start, stop, continuous,
  input master_transfer_done_irq, serial_clock_out,
  input slave_select_line_a_n, slave_select_line_b_n, slave_select_line_c_n,
  input [`CFG_W-1:0] cfg_read,
  input [`DATA_W-1:0] rx_data
);
  wire irq = master_transfer_done_irq;
  wire au = cfg_read[`CFG_AUTO_BIT];
  wire pol = cfg_read[`CFG_POL_BIT];
  wire [2:0] on = ~cfg_read[2:0];
  wire [2:0] sn = {slave_select_line_c_n, slave_select_line_b_n,
    slave_select_line_a_n};
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  //////////////////////////////////////////////////////////////////////////
  a_auto_idle:
    assert property (au && !busy |-> sn == 3'h7) else $error("sel idle");
  a_auto_busy:
    assert property (au && busy |-> sn == on) else $error("sel busy");
  a_manual_sel:
    assert property (!au |-> sn == on) else $error("sel manual");
  a_idle_level:
    assert property (!busy && !$past(busy) && $stable(pol)
      |-> serial_clock_out == pol) else $error("sck idle");
  a_irq_pulse:
    assert property (irq |=> !irq) else $error("irq long");
  a_busy_irq:
    assert property ($fell(busy) && cfg_read[`CFG_IRQ_BIT] |-> irq)
      else $error("irq missing");
  a_start_busy:
    assert property (start && !busy && !stop && !continuous |=> busy)
      else $error("start lost");
  a_rx_done:
    assert property ($changed(rx_data) |-> $fell(busy))
      else $error("rx early");
endmodule

/* File: verif/spi_slave_model.sv */
// Behavioural serial slave answering the master
`timescale 1ns/1ps
module spi_slave_model (
  input sck, mosi, sel_n, pol, pha, lsbf, load,
  input [5:0] len,
  input [31:0] tx_word,
  output reg miso = 1'b0,
  output reg [31:0] rx_word,
  output integer nbits
);
  integer idx;
  always @(posedge load or negedge sel_n) begin
    nbits = 0;
    rx_word = 0;
    idx = lsbf ? 0 : len - 1;
    if (!pha) miso = tx_word[idx[4:0]];
  end
  // No pull on the line: a stale bit must not pass for data
  always @(posedge sel_n) miso = ~miso;
  always @(sck) begin
    if (!sel_n && (sck != pol) != pha) begin
      if (lsbf) rx_word[nbits] = mosi;
      else rx_word = {rx_word[30:0], mosi};
      nbits = nbits + 1;
      if (pha) idx = lsbf ? idx + 1 : idx - 1;
    end else if (!sel_n) begin
      if (!pha) idx = lsbf ? idx + 1 : idx - 1;
      miso = tx_word[idx[4:0]];
    end
  end
endmodule

/* File: verif/testbench.sv */
// Self-checking bench for the serial master transfer controller
`timescale 1ns/1ps
module testbench;
  reg clk_sys, rst_n, auto_select, irq_enable, lsb_first, clk_invert;
  reg clk_phase, cfg_write, cfg_restore_load, start, continuous, stop;
  reg rx_read, load, slave_count_sel;
  reg [3:0] keep;
  reg [7:0] clk_divisor = 8'h14;
  reg [2:0] slave_sel;
  reg [5:0] xfer_len;
  reg [22:0] cfg_restore;
  reg [31:0] tx_data, s_tx, m;
  wire [22:0] cfg_read;
  wire [31:0] rx_data, s_rx, nb;
  wire busy, irq, serial_clock_out, serial_data_out, serial_data_in;
  wire slave_select_line_a_n, slave_select_line_b_n, slave_select_line_c_n;
  wire [2:0] sn = {slave_select_line_c_n, slave_select_line_b_n,
    slave_select_line_a_n};
  integer n_errors = 0, n_checks = 0, cyc = 0, edges = 0, i, t;
  // Divisor 20 gives the 160 ns serial clock
  spi_master_transfer_ctrl spi_master_transfer_ctrl_i (
    .clk_sys(clk_sys), .rst_n(rst_n), .slave_sel(slave_sel),
    .clk_divisor(clk_divisor), .auto_select(auto_select),
    .irq_enable(irq_enable), .lsb_first(lsb_first),
    .clk_invert(clk_invert), .clk_phase(clk_phase),
    .slave_count_sel(slave_count_sel), .cfg_write(cfg_write),
    .cfg_read(cfg_read), .cfg_restore(cfg_restore),
    .cfg_restore_load(cfg_restore_load), .start(start),
    .continuous(continuous), .stop(stop), .xfer_len(xfer_len),
    .tx_data(tx_data), .rx_read(rx_read), .rx_data(rx_data),
    .busy(busy), .master_transfer_done_irq(irq),
    .serial_clock_out(serial_clock_out),
    .serial_data_out(serial_data_out),
    .serial_data_in(serial_data_in),
    .slave_select_line_a_n(slave_select_line_a_n),
    .slave_select_line_b_n(slave_select_line_b_n),
    .slave_select_line_c_n(slave_select_line_c_n));
  spi_slave_model spi_slave_model_i (.sck(serial_clock_out),
    .mosi(serial_data_out), .sel_n(&sn), .pol(clk_invert),
    .pha(clk_phase), .lsbf(lsb_first), .load(load), .len(xfer_len),
    .tx_word(s_tx), .miso(serial_data_in), .rx_word(s_rx), .nbits(nb));
  //////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc = cyc + 1;
    if (cyc == 40000) begin
      n_errors = n_errors + 1;
      finish_test;
    end
  end
  always @(serial_clock_out) edges = edges + 1;
  task chk(input [31:0] s, e, input [39:0] nm);
    begin
      n_checks = n_checks + 1;
      if (s !== e) begin
        n_errors = n_errors + 1;
        $display("mismatch %0s exp %h seen %h", nm, e, s);
      end
    end
  endtask
  task finish_test;
    begin
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  task cfg(input r);
    begin
      {cfg_restore_load, cfg_write} = {r, !r};
      @(negedge clk_sys);
      {cfg_restore_load, cfg_write} = 2'h0;
      @(negedge clk_sys);
    end
  endtask
  // Caller raises the request; drop ends continuous mode mid-transfer
  task run(input drop);
    begin
      edges = 0;
      t = 0;
      @(negedge clk_sys);
      {start, rx_read, load} = 3'h0;
      while (busy !== 1'b1 && t < 8) begin
        @(negedge clk_sys);
        t = t + 1;
      end
      if (drop) continuous = 1'b0;
      while (busy !== 1'b0 && t < 3000) begin
        @(negedge clk_sys);
        t = t + 1;
      end
      m = 32'hffffffff >> (32 - xfer_len);
      chk(irq, irq_enable, "irq");
      chk(edges, 2 * xfer_len, "edges");
      chk(rx_data, s_tx & m, "rx");
      chk(s_rx, tx_data & m, "tx");
      chk(nb, xfer_len, "bits");
      chk(t, 2 * xfer_len * clk_divisor + 2, "time");
    end
  endtask
  initial begin
    {rst_n, auto_select, irq_enable, lsb_first, clk_invert, clk_phase,
      cfg_write, cfg_restore_load, start, continuous, stop, rx_read, load,
      slave_sel, xfer_len, cfg_restore, tx_data, s_tx,
      slave_count_sel} = 0;
    i = $urandom(67);
    repeat (10) @(negedge clk_sys);
    rst_n = 1'b1;
    for (i = 0; i < 16; i = i + 1) begin
      {auto_select, clk_invert, clk_phase, lsb_first} = i[3:0];
      irq_enable = $urandom;
      slave_count_sel = $urandom;
      slave_sel = auto_select ? 3'h1 << i % 3 : 3'h5;
      xfer_len = i < 2 ? 6'h01 << 5 * i : 6'h01 + $urandom % 32;
      {tx_data, s_tx} = {$urandom, $urandom};
      cfg(0);
      m = {15'h0000, slave_count_sel, clk_phase, clk_invert, lsb_first,
        irq_enable, auto_select, clk_divisor, slave_sel};
      chk({cfg_read[22], cfg_read[15:0]}, m, "rdbk");
      chk(sn, auto_select ? 3'h7 : 3'h7 ^ slave_sel, "sel");
      {load, start} = 2'h3;
      run(0);
    end
    cfg_restore = cfg_read;
    keep = {lsb_first, slave_sel};
    {lsb_first, slave_sel} = 4'h2;
    cfg(0);
    cfg(1);
    chk(cfg_read, cfg_restore, "cfg");
    // The slave model must follow the restored bit order
    {lsb_first, slave_sel} = keep;
    {load, start} = 2'h3;
    run(0);
    // While idle, stop is only visible on the selects in manual mode
    auto_select = 1'b0;
    cfg(0);
    chk(sn, 3'h7 ^ slave_sel, "man");
    stop = 1'b1;
    @(negedge clk_sys);
    stop = 1'b0;
    @(negedge clk_sys);
    chk(sn, 3'h7, "stop");
    auto_select = 1'b1;
    cfg(0);
    continuous = 1'b1;
    run(0);
    repeat (50) @(negedge clk_sys);
    chk(edges, 2 * xfer_len, "hold");
    rx_read = 1'b1;
    run(1);
    rx_read = 1'b1;
    @(negedge clk_sys);
    rx_read = 1'b0;
    repeat (50) @(negedge clk_sys);
    chk(edges, 2 * xfer_len, "last");
    finish_test;
  end
endmodule
bind spi_master_transfer_ctrl spi_master_props spi_master_props_i (
  .clk_sys(clk_sys), .rst_n(rst_n), .busy(busy), .start(start),
  .stop(stop), .continuous(continuous),
  .master_transfer_done_irq(master_transfer_done_irq),
  .serial_clock_out(serial_clock_out),
  .slave_select_line_a_n(slave_select_line_a_n),
  .slave_select_line_b_n(slave_select_line_b_n),
  .slave_select_line_c_n(slave_select_line_c_n),
  .cfg_read(cfg_read), .rx_data(rx_data));
